// file: verilog/dpbs_pkg.sv
package dpbs_pkg;

  // ****************************************************************
  // Logical address map.
  // ****************************************************************
  localparam logic [23:0] DPBS_ACTIVE_BASE = 24'h000000;
  localparam logic [23:0] DPBS_INACTIVE_BASE = 24'h400000;
  localparam logic [23:0] DPBS_RESET_VECTOR = 24'h000000;
  localparam logic [23:0] DPBS_RESET_TARGET = 24'h000002;
  localparam logic [23:0] DPBS_VECTOR_END = 24'h000200;
  localparam logic [23:0] DPBS_IVT_FIRST = 24'h000004;
  localparam logic [23:0] DPBS_IVT_LAST = 24'h0000FF;
  localparam logic [23:0] DPBS_SEGMENT_UNIT = 24'h000800;
  localparam logic [23:0] DPBS_SINGLE_CFG_FIRST = 24'h0ABF00;
  localparam logic [23:0] DPBS_SINGLE_CFG_LAST = 24'h0ABF2C;
  localparam logic [23:0] DPBS_DUAL_CFG_FIRST = 24'h055F00;
  localparam logic [23:0] DPBS_DUAL_SEQ_WORD = 24'h055FFC;
  localparam logic [23:0] DPBS_OTP_FIRST = 24'h801700;
  localparam logic [23:0] DPBS_OTP_LAST = 24'h8017FE;
  localparam logic [23:0] DPBS_USER_LAST = 24'h7FFFFF;
  localparam logic [23:0] DPBS_SINGLE_LIMIT = 24'h0ABFFE;
  localparam logic [23:0] DPBS_DUAL_LIMIT = 24'h055FFE;

  // ****************************************************************
  // Boot sequence word.
  // ****************************************************************
  localparam int DPBS_SEQ_WIDTH = 24;
  localparam int DPBS_SEQ_NUM_WIDTH = 12;
  localparam logic [11:0] DPBS_SEQ_MAX = 12'hFFF;
  localparam int DPBS_BOOT_SEGMENT_LIMIT_FIELD_WIDTH = 13;

  // ****************************************************************
  // Register offsets, fields and reset values.
  // ****************************************************************
  localparam logic [7:0] DPBS_NVM_CONTROL_OFS = 8'h00;
  localparam logic [7:0] DPBS_BOOT_STATUS_OFS = 8'h04;
  localparam logic [7:0] DPBS_SEQ_NUMBERS_OFS = 8'h08;
  localparam logic [7:0] DPBS_SEGMENT_OFS = 8'h0C;
  localparam int DPBS_SWAP_BIT = 0;
  localparam int DPBS_DUAL_BIT = 8;
  localparam int DPBS_P2_ACTIVE_BIT = 10;
  localparam logic [31:0] DPBS_ZERO_WORD = 32'h00000000;

  // ****************************************************************
  // Region codes reported with every fetch.
  // ****************************************************************
  localparam logic [2:0] DPBS_RGN_VECTOR = 3'h0;
  localparam logic [2:0] DPBS_RGN_IVT = 3'h1;
  localparam logic [2:0] DPBS_RGN_ALTERNATE_VECTOR_TABLE = 3'h2;
  localparam logic [2:0] DPBS_RGN_BOOT = 3'h3;
  localparam logic [2:0] DPBS_RGN_GENERAL = 3'h4;
  localparam logic [2:0] DPBS_RGN_CONFIG = 3'h5;
  localparam logic [2:0] DPBS_RGN_OTP = 3'h6;
  localparam logic [2:0] DPBS_RGN_NONE = 3'h7;

  typedef enum logic [1:0] {
    DPBS_ST_LOAD = 2'b01,
    DPBS_ST_RUN = 2'b10
  } dpbs_state_type;

endpackage

// file: verilog/dpbs_boot_select.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

module dpbs_boot_select
  import dpbs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cfg_dual_mode,
  input wire logic [23:0] cfg_seq_word_p1,
  input wire logic [23:0] cfg_seq_word_p2,
  input wire logic cfg_seq_intact_p1,
  input wire logic cfg_seq_intact_p2,
  input wire logic [12:0] cfg_boot_limit_p1,
  input wire logic [12:0] cfg_boot_limit_p2,
  input wire logic cfg_alt_vec_disable_p1,
  input wire logic cfg_alt_vec_disable_p2,
  input wire logic cfg_write_protect_p1,
  input wire logic cfg_write_protect_p2,
  input wire logic swap_exec,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic prog_req,
  input wire logic prog_erase,
  input wire logic [23:0] prog_addr,
  output logic boot_done,
  output logic fetch_valid,
  output logic fetch_fault,
  output logic [23:0] fetch_phys_addr,
  output logic [2:0] fetch_region,
  output logic prog_grant,
  output logic prog_reject,
  output logic [23:0] prog_phys_addr
);

  // ****************************************************************
  // Reset-time load of the configuration words.
  // ****************************************************************
  dpbs_state_type state_reg;
  logic dual_reg;
  logic reset_sel_reg;
  logic active_p2_reg;
  logic [11:0] seq_num_p1_reg;
  logic [11:0] seq_num_p2_reg;
  logic bad_p1_reg;
  logic bad_p2_reg;
  logic [12:0] boot_segment_limit_field_p1_reg;
  logic [12:0] boot_segment_limit_field_p2_reg;
  logic alternate_vector_table_dis_p1_reg;
  logic alternate_vector_table_dis_p2_reg;
  logic wp_p1_reg;
  logic wp_p2_reg;

  logic [11:0] num_p1;
  logic [11:0] num_p2;
  logic valid_p1;
  logic valid_p2;
  logic pick_p2;

  // A word is valid when its upper half is the complement of its number.
  assign valid_p1 = cfg_seq_word_p1[23:12] == ~cfg_seq_word_p1[11:0];
  assign valid_p2 = cfg_seq_word_p2[23:12] == ~cfg_seq_word_p2[11:0];
  assign num_p1 = (valid_p1 && cfg_seq_intact_p1) ?
                  cfg_seq_word_p1[11:0] : DPBS_SEQ_MAX;
  assign num_p2 = (valid_p2 && cfg_seq_intact_p2) ?
                  cfg_seq_word_p2[11:0] : DPBS_SEQ_MAX;

  assign pick_p2 = !cfg_dual_mode ? 1'b0 :
                   (cfg_seq_intact_p1 != cfg_seq_intact_p2) ?
                   cfg_seq_intact_p2 :
                   cfg_seq_intact_p1 && num_p2 < num_p1;

  always_ff @(posedge clk)
  begin
    if (reset)
      state_reg <= DPBS_ST_LOAD;
    else
      case (state_reg)
        DPBS_ST_LOAD: state_reg <= DPBS_ST_RUN;
        DPBS_ST_RUN: state_reg <= DPBS_ST_RUN;
        default: state_reg <= DPBS_ST_LOAD;
      endcase
  end

  // Configuration is captured once per reset; later flash changes wait.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dual_reg <= 1'b0;
      reset_sel_reg <= 1'b0;
      seq_num_p1_reg <= DPBS_SEQ_MAX;
      seq_num_p2_reg <= DPBS_SEQ_MAX;
      bad_p1_reg <= 1'b0;
      bad_p2_reg <= 1'b0;
      boot_segment_limit_field_p1_reg <= '0;
      boot_segment_limit_field_p2_reg <= '0;
      alternate_vector_table_dis_p1_reg <= 1'b1;
      alternate_vector_table_dis_p2_reg <= 1'b1;
      wp_p1_reg <= 1'b1;
      wp_p2_reg <= 1'b1;
    end
    else if (state_reg == DPBS_ST_LOAD)
    begin
      dual_reg <= cfg_dual_mode;
      reset_sel_reg <= pick_p2;
      seq_num_p1_reg <= num_p1;
      seq_num_p2_reg <= num_p2;
      bad_p1_reg <= !cfg_seq_intact_p1;
      bad_p2_reg <= !cfg_seq_intact_p2;
      boot_segment_limit_field_p1_reg <= cfg_boot_limit_p1;
      boot_segment_limit_field_p2_reg <= cfg_boot_limit_p2;
      alternate_vector_table_dis_p1_reg <= cfg_alt_vec_disable_p1;
      alternate_vector_table_dis_p2_reg <= cfg_alt_vec_disable_p2;
      wp_p1_reg <= cfg_write_protect_p1;
      wp_p2_reg <= cfg_write_protect_p2;
    end
  end

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic ph_write_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] rd_word;
  logic sw_swap;
  logic bus_take;

  assign bus_take = hsel && htrans[1] && hready;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ph_write_reg <= 1'b0;
      ph_addr_reg <= '0;
    end
    else if (hready)
    begin
      ph_write_reg <= bus_take && hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  assign sw_swap = ph_write_reg && ph_addr_reg == DPBS_NVM_CONTROL_OFS &&
                   hwdata[DPBS_SWAP_BIT];

  // ****************************************************************
  // Active partition tracking.
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      active_p2_reg <= 1'b0;
    else if (state_reg == DPBS_ST_LOAD)
      active_p2_reg <= pick_p2;
    else if (dual_reg && (swap_exec || sw_swap))
      active_p2_reg <= !active_p2_reg;
  end

  // Settings of the active half; inactive security rules the other.
  logic [12:0] act_boot_segment_limit_field;
  logic act_alternate_vector_table_dis;
  logic inact_wp;
  logic bs_present;
  logic [23:0] bs_end;
  logic [23:0] alternate_vector_table_base;

  assign act_boot_segment_limit_field = active_p2_reg ? boot_segment_limit_field_p2_reg : boot_segment_limit_field_p1_reg;
  assign act_alternate_vector_table_dis = active_p2_reg ? alternate_vector_table_dis_p2_reg :
                        alternate_vector_table_dis_p1_reg;
  assign inact_wp = active_p2_reg ? wp_p1_reg : wp_p2_reg;
  assign bs_end = 24'(act_boot_segment_limit_field) * DPBS_SEGMENT_UNIT;
  assign bs_present = bs_end > DPBS_VECTOR_END;
  assign alternate_vector_table_base = 24'(act_boot_segment_limit_field - 13'h0001) * DPBS_SEGMENT_UNIT;

  always_comb
  begin
    rd_word = DPBS_ZERO_WORD;
    case (haddr[7:0])
      DPBS_NVM_CONTROL_OFS:
      begin
        rd_word[DPBS_P2_ACTIVE_BIT] = active_p2_reg;
        rd_word[DPBS_DUAL_BIT] = dual_reg;
      end
      DPBS_BOOT_STATUS_OFS:
      begin
        rd_word[0] = reset_sel_reg;
        rd_word[1] = bad_p1_reg;
        rd_word[2] = bad_p2_reg;
        rd_word[3] = state_reg == DPBS_ST_RUN;
      end
      DPBS_SEQ_NUMBERS_OFS:
      begin
        rd_word[11:0] = seq_num_p1_reg;
        rd_word[27:16] = seq_num_p2_reg;
      end
      DPBS_SEGMENT_OFS:
      begin
        rd_word[12:0] = act_boot_segment_limit_field;
        rd_word[16] = bs_present && !act_alternate_vector_table_dis;
      end
      default: rd_word = DPBS_ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      hrdata <= DPBS_ZERO_WORD;
    else if (bus_take && !hwrite)
      hrdata <= rd_word;
  end

  always_ff @(posedge clk)
  begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    boot_done <= !reset && state_reg == DPBS_ST_RUN;
  end

  // ****************************************************************
  // Fetch mapping.
  // ****************************************************************
  logic f_ok;
  logic [2:0] f_rgn;
  logic [23:0] f_phys;
  logic [23:0] f_limit;

  assign f_limit = dual_reg ? DPBS_DUAL_LIMIT : DPBS_SINGLE_LIMIT;

  always_comb
  begin
    f_ok = 1'b0;
    f_phys = fetch_addr;
    if (fetch_addr <= f_limit)
    begin
      f_ok = 1'b1;
      f_phys = dual_reg ? {1'b0, active_p2_reg, fetch_addr[21:0]} :
               fetch_addr;
    end
    if (fetch_addr == DPBS_RESET_VECTOR)
      f_rgn = DPBS_RGN_VECTOR;
    else if (fetch_addr >= DPBS_IVT_FIRST && fetch_addr <= DPBS_IVT_LAST)
      f_rgn = DPBS_RGN_IVT;
    else if (fetch_addr < DPBS_VECTOR_END)
      f_rgn = DPBS_RGN_VECTOR;
    else if (dual_reg ? fetch_addr >= DPBS_DUAL_CFG_FIRST :
             (fetch_addr >= DPBS_SINGLE_CFG_FIRST &&
              fetch_addr <= DPBS_SINGLE_CFG_LAST))
      f_rgn = DPBS_RGN_CONFIG;
    else if (bs_present && !act_alternate_vector_table_dis && fetch_addr >= alternate_vector_table_base &&
             fetch_addr < bs_end)
      f_rgn = DPBS_RGN_ALTERNATE_VECTOR_TABLE;
    else if (bs_present && fetch_addr < bs_end)
      f_rgn = DPBS_RGN_BOOT;
    else
      f_rgn = DPBS_RGN_GENERAL;
    if (!f_ok)
      f_rgn = DPBS_RGN_NONE;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fetch_valid <= 1'b0;
      fetch_fault <= 1'b0;
      fetch_phys_addr <= '0;
      fetch_region <= DPBS_RGN_NONE;
    end
    else
    begin
      fetch_valid <= fetch_req && f_ok && state_reg == DPBS_ST_RUN;
      fetch_fault <= fetch_req && !f_ok && state_reg == DPBS_ST_RUN;
      fetch_phys_addr <= f_phys;
      fetch_region <= f_rgn;
    end
  end

  // ****************************************************************
  // Programming access.
  // ****************************************************************
  logic p_ok;
  logic p_otp;
  logic p_inact;
  logic [23:0] p_phys;
  logic [21:0] p_ofs;

  assign p_otp = prog_addr >= DPBS_OTP_FIRST && prog_addr <= DPBS_OTP_LAST;
  assign p_inact = dual_reg && prog_addr[22] && prog_addr <= DPBS_USER_LAST;
  assign p_ofs = prog_addr[21:0];

  always_comb
  begin
    p_ok = 1'b0;
    p_phys = prog_addr;
    if (p_otp)
      p_ok = !prog_erase;
    else if (dual_reg && prog_addr <= DPBS_USER_LAST)
    begin
      p_ok = p_ofs <= DPBS_DUAL_LIMIT[21:0] &&
             !(p_inact && inact_wp);
      p_phys = {1'b0, active_p2_reg ^ prog_addr[22], p_ofs};
    end
    else if (!dual_reg)
      p_ok = prog_addr <= DPBS_SINGLE_LIMIT;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prog_grant <= 1'b0;
      prog_reject <= 1'b0;
      prog_phys_addr <= '0;
    end
    else
    begin
      prog_grant <= prog_req && p_ok && state_reg == DPBS_ST_RUN;
      prog_reject <= prog_req && !(p_ok && state_reg == DPBS_ST_RUN);
      prog_phys_addr <= p_phys;
    end
  end

endmodule

// file: tb/dpbs_core_model.sv
`timescale 1ns/1ps

module dpbs_core_model
  import dpbs_pkg::*;
(
  input wire logic clk,
  output logic swap_exec,
  output logic fetch_req,
  output logic [23:0] fetch_addr,
  output logic prog_req,
  output logic prog_erase,
  output logic [23:0] prog_addr
);
  // ****************************************************************
  // Core side: fetch, program and swap requests.
  // ****************************************************************
  logic [127:0] otp_used = 128'h0;

  initial {swap_exec, fetch_req, fetch_addr, prog_req, prog_erase,
    prog_addr} = '0;

  // Released address lines show the inverse of the last value.
  task automatic fetch(input logic [23:0] a);
    @(posedge clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
    #1;
  endtask

  task automatic prog(input logic e, input logic [23:0] a);
    logic otp;
    otp = a >= DPBS_OTP_FIRST && a <= DPBS_OTP_LAST && !e;
    if (otp && otp_used[a[7:1]]) return;
    if (otp) otp_used[a[7:1]] = 1'b1;
    @(posedge clk);
    prog_req <= 1'b1;
    prog_erase <= e;
    prog_addr <= a;
    @(posedge clk);
    prog_req <= 1'b0;
    prog_erase <= ~e;
    prog_addr <= ~a;
    #1;
  endtask

  task automatic swap();
    @(posedge clk);
    swap_exec <= 1'b1;
    @(posedge clk);
    swap_exec <= 1'b0;
    #1;
  endtask
endmodule

// file: tb/dpbs_chk.sv
`timescale 1ns/1ps

module dpbs_chk
  import dpbs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic boot_done,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic fetch_fault,
  input wire logic [23:0] fetch_phys_addr,
  input wire logic prog_req,
  input wire logic prog_erase,
  input wire logic [23:0] prog_addr,
  input wire logic prog_grant,
  input wire logic prog_reject
);
  // ****************************************************************
  // Port checks.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_fetch;
    boot_done && fetch_req;
  endsequence
  sequence s_otp_erase;
    boot_done && prog_req && prog_erase && prog_addr >= DPBS_OTP_FIRST
      && prog_addr <= DPBS_OTP_LAST;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_fetch_answer: assert property (
    s_fetch |=> fetch_valid != fetch_fault)
    else $error("fetch answer wrong");
  a_fetch_quiet: assert property (
    !fetch_req |=> !fetch_valid && !fetch_fault)
    else $error("fetch result without request");
  a_inactive_fault: assert property (
    s_fetch ##0 fetch_addr >= DPBS_INACTIVE_BASE |=> fetch_fault)
    else $error("inactive fetch executed");
  a_map_offset: assert property (
    s_fetch ##1 fetch_valid |->
    fetch_phys_addr[21:0] == $past(fetch_addr[21:0]) && !fetch_phys_addr[23])
    else $error("fetch offset changed");
  a_otp_no_erase: assert property (
    s_otp_erase |=> prog_reject && !prog_grant)
    else $error("otp erase granted");
  a_prog_answer: assert property (
    boot_done && prog_req |=> prog_grant != prog_reject)
    else $error("program answer wrong");
  a_prog_quiet: assert property (
    !prog_req |=> !prog_grant && !prog_reject)
    else $error("program result without request");
  a_boot_hold: assert property (boot_done |=> boot_done)
    else $error("boot done dropped");
  a_boot_start: assert property ($fell(reset) |-> ##[1:4] boot_done)
    else $error("boot load too slow");
endmodule

bind dpbs_boot_select dpbs_chk dpbs_chk_i (.*);

// file: tb/tb_dpbs_boot_select.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end

module tb_dpbs_boot_select
  import dpbs_pkg::*;
;
  // ****************************************************************
  // Stimulus, bus master and scenarios.
  // ****************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic cfg_dual_mode = 1'b0;
  logic [23:0] cfg_seq_word_p1 = 24'h0, cfg_seq_word_p2 = 24'h0;
  logic cfg_seq_intact_p1 = 1'b1, cfg_seq_intact_p2 = 1'b1;
  logic [12:0] cfg_boot_limit_p1 = 13'h010, cfg_boot_limit_p2 = 13'h020;
  logic cfg_alt_vec_disable_p1 = 1'b0, cfg_alt_vec_disable_p2 = 1'b0;
  logic cfg_write_protect_p1 = 1'b0, cfg_write_protect_p2 = 1'b0;
  wire logic hreadyout, hresp, boot_done, fetch_valid, fetch_fault;
  wire logic prog_grant, prog_reject, swap_exec, fetch_req;
  wire logic prog_req, prog_erase;
  wire logic [31:0] hrdata;
  wire logic [23:0] fetch_phys_addr, prog_phys_addr, fetch_addr, prog_addr;
  wire logic [2:0] fetch_region;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;

  dpbs_boot_select dpbs_boot_select_i (.*, .hready(hreadyout));
  dpbs_core_model dpbs_core_model_i (.*);

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [23:0] sq(input logic [11:0] n);
    return {~n, n};
  endfunction

  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic sel(input logic d, input logic [23:0] s1,
    input logic [23:0] s2, input logic k1, input logic k2, input logic e);
    @(posedge clk);
    reset <= 1'b1;
    cfg_dual_mode <= d;
    cfg_seq_word_p1 <= s1;
    cfg_seq_word_p2 <= s2;
    cfg_seq_intact_p1 <= k1;
    cfg_seq_intact_p2 <= k2;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int n = 0; n < 8 && boot_done !== 1'b1; n++) @(posedge clk);
    #1;
    `CHK(boot_done, 1'b1)
    ahb(1'b0, DPBS_NVM_CONTROL_OFS, DPBS_ZERO_WORD);
    `CHK(rd[DPBS_P2_ACTIVE_BIT], e)
    `CHK(rd[DPBS_DUAL_BIT], d)
    dpbs_core_model_i.fetch(24'h000800);
    `CHK(fetch_phys_addr, {1'b0, e, 22'h000800})
  endtask

  task automatic fchk(input logic [23:0] a, input logic [2:0] r);
    dpbs_core_model_i.fetch(a);
    `CHK(fetch_valid, 1'b1)
    `CHK(fetch_region, r)
  endtask

  task automatic t_select();
    sel(1'b1, sq(12'h005), sq(12'h003), 1'b1, 1'b1, 1'b1);
    sel(1'b1, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    sel(1'b1, sq(12'h007), sq(12'h007), 1'b1, 1'b1, 1'b0);
    sel(1'b1, sq(12'h009), sq(12'h002), 1'b0, 1'b0, 1'b0);
    sel(1'b1, sq(12'h002), sq(12'h009), 1'b0, 1'b1, 1'b1);
    sel(1'b1, sq(12'h009), sq(12'h002), 1'b1, 1'b0, 1'b0);
    sel(1'b1, 24'h000005, sq(12'hFFE), 1'b1, 1'b1, 1'b1);
    ahb(1'b0, DPBS_SEQ_NUMBERS_OFS, DPBS_ZERO_WORD);
    `CHK(rd[11:0], 12'hFFF)
    `CHK(rd[27:16], 12'hFFE)
    sel(1'b0, sq(12'h009), sq(12'h002), 1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_swap();
    sel(1'b1, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    cfg_seq_word_p1 <= sq(12'h009);
    ahb(1'b0, DPBS_NVM_CONTROL_OFS, DPBS_ZERO_WORD);
    `CHK(rd[DPBS_P2_ACTIVE_BIT], 1'b0)
    dpbs_core_model_i.swap();
    ahb(1'b0, DPBS_NVM_CONTROL_OFS, DPBS_ZERO_WORD);
    `CHK(rd[DPBS_P2_ACTIVE_BIT], 1'b1)
    dpbs_core_model_i.fetch(24'h000800);
    `CHK(fetch_phys_addr, 24'h400800)
    ahb(1'b0, DPBS_SEGMENT_OFS, DPBS_ZERO_WORD);
    `CHK(rd[12:0], 13'h020)
    ahb(1'b0, DPBS_BOOT_STATUS_OFS, DPBS_ZERO_WORD);
    `CHK(rd[0], 1'b0)
    ahb(1'b1, DPBS_NVM_CONTROL_OFS, 32'h00000001);
    ahb(1'b0, DPBS_NVM_CONTROL_OFS, DPBS_ZERO_WORD);
    `CHK(rd[DPBS_P2_ACTIVE_BIT], 1'b0)
    sel(1'b1, sq(12'h009), sq(12'h005), 1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_region();
    sel(1'b1, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    fchk(24'h000000, DPBS_RGN_VECTOR);
    fchk(24'h000002, DPBS_RGN_VECTOR);
    fchk(24'h000004, DPBS_RGN_IVT);
    fchk(24'h0000FE, DPBS_RGN_IVT);
    fchk(24'h007800, DPBS_RGN_ALTERNATE_VECTOR_TABLE);
    fchk(24'h000200, DPBS_RGN_BOOT);
    fchk(24'h008000, DPBS_RGN_GENERAL);
    fchk(24'h055FFC, DPBS_RGN_CONFIG);
    dpbs_core_model_i.fetch(24'h455FFC);
    `CHK(fetch_fault, 1'b1)
    ahb(1'b0, DPBS_SEGMENT_OFS, DPBS_ZERO_WORD);
    `CHK(rd[16], 1'b1)
    ahb(1'b0, 8'h40, DPBS_ZERO_WORD);
    `CHK(rd, DPBS_ZERO_WORD)
    sel(1'b0, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    fchk(24'h0ABF00, DPBS_RGN_CONFIG);
    fchk(24'h0ABF2C, DPBS_RGN_CONFIG);
  endtask

  task automatic t_prog();
    sel(1'b1, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    dpbs_core_model_i.prog(1'b0, 24'h400100);
    `CHK(prog_grant, 1'b1)
    `CHK(prog_phys_addr, 24'h400100)
    @(posedge clk);
    cfg_write_protect_p2 <= 1'b1;
    sel(1'b1, sq(12'h003), sq(12'h005), 1'b1, 1'b1, 1'b0);
    dpbs_core_model_i.prog(1'b0, 24'h400100);
    `CHK(prog_reject, 1'b1)
    dpbs_core_model_i.prog(1'b0, DPBS_OTP_FIRST);
    `CHK(prog_grant, 1'b1)
    dpbs_core_model_i.prog(1'b1, DPBS_OTP_FIRST);
    `CHK(prog_reject, 1'b1)
    dpbs_core_model_i.prog(1'b0, DPBS_OTP_LAST);
    `CHK(prog_grant, 1'b1)
  endtask

  initial
  begin
    t_select();
    t_swap();
    t_region();
    t_prog();
    complete_run();
  end
endmodule
